//--- fkc_defines.vh
// Constants for the front key configuration menu
`ifndef FKC_DEFINES_VH
`define FKC_DEFINES_VH
`define FKC_MAX_SESSIONS      5'd25
`define FKC_ITEM_COUNT        5'd22
`define FKC_ITEM_FIRST        5'd1
`define FKC_ITEM_LOCK         5'd22
`define FKC_ITEM_UNIT_RES     5'd8
`define FKC_ITEM_HEAT_COOL    5'd11
`define FKC_MENU_GROUP        4'h3
`define FKC_METER_TYPE_HC     3'd6
`define FKC_CLK_HZ            40000000
`define FKC_TIMEOUT_S         240
`define FKC_LOCK_HOLD_S       5
`define FKC_ENTRY_HOLD_S      9
`define FKC_DEBOUNCE_MS       20
`define FKC_LONG_MS           1000
`define FKC_DIGITS            3'd4
`endif

//--- fkc_key_filter.v
// Key debouncer with brief and long press classification
`timescale 1ns/1ps
module fkc_key_filter #(
    parameter DEB_CYC  = 800000,
    parameter LONG_CYC = 40000000
) (
    // Clock and reset
    input  wire mclk,
    input  wire rst,
    // Raw key and results
    input  wire key_raw,
    output reg  key_level,
    output reg  brief_press,
    output reg  long_start,
    output reg  [31:0] held_cyc
);
    reg [31:0] deb_cnt;
    reg        long_seen;

    // Debounce: level accepted only after it has stood steady
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            deb_cnt     <= 32'h0;
            key_level   <= 1'b0;
            brief_press <= 1'b0;
            long_start  <= 1'b0;
            held_cyc    <= 32'h0;
            long_seen   <= 1'b0;
        end else begin
            brief_press <= 1'b0;
            long_start  <= 1'b0;
            if (key_raw == key_level) begin
                deb_cnt <= 32'h0;
            end else if (deb_cnt >= DEB_CYC - 1) begin
                deb_cnt   <= 32'h0;
                key_level <= key_raw;
                if (!key_raw && !long_seen) begin
                    brief_press <= 1'b1;
                end
            end else begin
                deb_cnt <= deb_cnt + 32'h1;
            end
            // Hold time counter, saturating
            if (key_level) begin
                if (held_cyc != 32'hffffffff) begin
                    held_cyc <= held_cyc + 32'h1;
                end
                if (held_cyc == LONG_CYC - 1) begin
                    long_start <= 1'b1;
                    long_seen  <= 1'b1;
                end
            end else begin
                held_cyc  <= 32'h0;
                long_seen <= 1'b0;
            end
        end
    end
endmodule

//--- fkc_value_mem.v
// Small parameter store, one 4-digit BCD word per menu item
`timescale 1ns/1ps
module fkc_value_mem #(
    parameter AW = 5,
    parameter DW = 16
) (
    // Clock
    input  wire          mclk,
    // Write port
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    // Read port
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    integer      i;

    // Known contents at power-up so an edit starts from zeros
    initial begin
        for (i = 0; i < (1 << AW); i = i + 1) begin
            mem[i] = {DW{1'b0}};
        end
    end

    // Registered read; no reset so it maps to RAM
    always @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

//--- fkc_menu.v
// Front key configuration menu controller
// Behaviour
// - At most 25 sessions; afterwards entry refused until total reset.
// - Menu reachable by default while in transport state.
// - Transport state ends at first integration or confirmed lock item.
// - Only total reset returns the device to transport state.
// - Outside transport, access reopens only after a seal-break event.
// - Long primary hold in menu exits to the other display menus.
// - Four minutes in menu times out back to first normal reading.
// - Secondary held 5 s on lock item exits and locks access.
// - Operating exits lock; transport primary/timeout exits keep access open.
// - Primary held 9 s in normal menu enters menu on release.
// - Brief primary press advances to next parameter.
// - No secondary readings; index always shown as four digits.
// - Secondary press on item starts edit at leftmost digit.
// - Brief secondary press in edit steps the flashing digit.
// - Brief primary moves right; on last digit stores and shows OK.
// - Unit/resolution code change held pending until menu exit.
// - Disabled items show Off; secondary shows frames instead of editing.
// - 22 items, index 3-001 to 3-022, lock item last.
// - Heat/cool limit editable only for meter type 6, else Off.
`timescale 1ns/1ps
`include "fkc_defines.vh"
module fkc_menu #(
    parameter CLK_HZ      = `FKC_CLK_HZ,
    parameter [39:0] TIMEOUT_CYC = 40'd1 * `FKC_TIMEOUT_S * `FKC_CLK_HZ,
    parameter LOCK_CYC    = `FKC_LOCK_HOLD_S * `FKC_CLK_HZ,
    parameter ENTRY_CYC   = `FKC_ENTRY_HOLD_S * `FKC_CLK_HZ,
    parameter DEB_CYC     = (`FKC_DEBOUNCE_MS * (`FKC_CLK_HZ / 1000)),
    parameter LONG_CYC    = (`FKC_LONG_MS * (`FKC_CLK_HZ / 1000))
) (
    // Clock and total reset
    input  wire        mclk,
    input  wire        rst,
    // Front keys, high while pressed
    input  wire        key_primary,
    input  wire        key_secondary,
    // Meter events and configuration
    input  wire        seal_break,
    input  wire        first_integration,
    input  wire        access_default_on,
    input  wire [2:0]  meter_type,
    input  wire [21:0] item_disabled,
    // Display
    output reg         in_menu,
    output reg  [15:0] disp_index,
    output wire [15:0] disp_value,
    output reg  [3:0]  flash_digit,
    output reg         show_off,
    output reg         show_frames,
    output reg         show_ok,
    output reg         to_other_menus,
    output reg         to_first_reading,
    // State toward the meter
    output reg         transport,
    output reg         access_open,
    output reg  [4:0]  session_count,
    output reg  [15:0] unit_res_code,
    output reg         unit_res_commit
);
    localparam ST_NORMAL = 2'd0;
    localparam ST_BROWSE = 2'd1;
    localparam ST_EDIT   = 2'd2;

    reg  [1:0]  state;
    reg  [4:0]  item;
    reg  [2:0]  digit;
    reg  [15:0] edit_val;
    reg  [15:0] pend_code;
    reg         pend_valid;
    reg  [39:0] menu_timer; // Four minutes at 40 MHz needs more than 32 bits
    reg         arm_entry;
    wire [4:0]  idx_tens;
    wire [4:0]  idx_ones;
    reg         wr_en;
    wire        p_level;
    wire        p_brief;
    wire        p_long;
    wire [31:0] p_held;
    wire        s_level;
    wire        s_brief;
    wire        s_long;
    wire [31:0] s_held;
    wire [15:0] rd_data;
    wire        item_off;
    wire        granted_ok;
    wire [3:0]  cur_nib;
    wire [3:0]  next_nib;

    // Both keys share one debounce and hold classifier design
    fkc_key_filter #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_pri (
        .mclk        (mclk),
        .rst         (rst),
        .key_raw     (key_primary),
        .key_level   (p_level),
        .brief_press (p_brief),
        .long_start  (p_long),
        .held_cyc    (p_held)
    );
    fkc_key_filter #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_sec (
        .mclk        (mclk),
        .rst         (rst),
        .key_raw     (key_secondary),
        .key_level   (s_level),
        .brief_press (s_brief),
        .long_start  (s_long),
        .held_cyc    (s_held)
    );

    // Stored parameter values
    fkc_value_mem #(.AW(5), .DW(16)) u_mem (
        .mclk    (mclk),
        .wr_en   (wr_en),
        .wr_addr (item),
        .wr_data (edit_val),
        .rd_addr (item),
        .rd_data (rd_data)
    );

    // Disabled at factory, or heat/cool limit on a non type-6 meter
    assign item_off = item_disabled[item - 5'd1] |
                      ((item == `FKC_ITEM_HEAT_COOL) && (meter_type != `FKC_METER_TYPE_HC));
    // Entry allowed only under the lifetime limit
    assign granted_ok = access_open && (session_count < `FKC_MAX_SESSIONS);
    // Shown value: the edit copy while editing, else pending or stored
    assign disp_value = (state == ST_EDIT) ? edit_val :
                        ((item == `FKC_ITEM_UNIT_RES) && pend_valid) ? pend_code : rd_data;
    assign cur_nib  = edit_val[15 - 4 * digit -: 4];
    assign next_nib = (cur_nib >= 4'h9) ? 4'h0 : cur_nib + 4'h1;

    // Item number split into two BCD digits
    assign idx_tens = item / 5'd10;
    assign idx_ones = item % 5'd10;

    // Index shown as four digits 3-0xx, never a secondary reading
    always @* begin
        disp_index = {`FKC_MENU_GROUP, 4'h0, idx_tens[3:0], idx_ones[3:0]};
    end

    // Menu state machine, session limits and transport handling
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state            <= ST_NORMAL;
            item             <= `FKC_ITEM_FIRST;
            digit            <= 3'd0;
            edit_val         <= 16'h0;
            pend_code        <= 16'h0;
            pend_valid       <= 1'b0;
            menu_timer       <= 40'h0;
            arm_entry        <= 1'b0;
            wr_en            <= 1'b0;
            in_menu          <= 1'b0;
            flash_digit      <= 4'h0;
            show_off         <= 1'b0;
            show_frames      <= 1'b0;
            show_ok          <= 1'b0;
            to_other_menus   <= 1'b0;
            to_first_reading <= 1'b0;
            transport        <= 1'b1;
            access_open      <= 1'b1; // reset default, corrected next cycle by strap
            session_count    <= 5'd0;
            unit_res_code    <= 16'h0;
            unit_res_commit  <= 1'b0;
        end else begin
            wr_en            <= 1'b0;
            to_other_menus   <= 1'b0;
            to_first_reading <= 1'b0;
            unit_res_commit  <= 1'b0;
            show_off         <= (state != ST_NORMAL) && item_off;
            show_frames      <= (state == ST_BROWSE) && item_off && s_level;
            // Transport ends at first integration
            if (first_integration && transport) begin
                transport <= 1'b0;
            end
            // Seal break reopens access once outside transport
            if (seal_break && !transport) begin
                access_open <= 1'b1;
            end
            // Strap sampled while idle in transport before any session
            if (transport && session_count == 5'd0 && state == ST_NORMAL && !arm_entry) begin
                access_open <= access_default_on;
            end
            if (state != ST_NORMAL) begin
                menu_timer <= menu_timer + 40'h1;
            end
            case (state)
                ST_NORMAL: begin
                    // Arm after a 9 s hold, grant at release
                    if (p_level && p_held == ENTRY_CYC - 1) begin
                        arm_entry <= 1'b1;
                    end
                    if (!p_level && arm_entry) begin
                        arm_entry <= 1'b0;
                        if (granted_ok) begin
                            state         <= ST_BROWSE;
                            in_menu       <= 1'b1;
                            item          <= `FKC_ITEM_FIRST;
                            menu_timer    <= 40'h0;
                            session_count <= session_count + 5'd1;
                        end
                    end
                end
                ST_BROWSE: begin
                    show_ok <= show_ok & ~(p_brief | s_level);
                    if (p_brief) begin
                        item <= (item == `FKC_ITEM_COUNT) ? `FKC_ITEM_FIRST : item + 5'd1;
                    end else if (s_brief && !item_off && item != `FKC_ITEM_LOCK) begin
                        // Entered on release so the opening press does not also step the digit
                        state       <= ST_EDIT;
                        digit       <= 3'd0;
                        flash_digit <= 4'b1000;
                        edit_val    <= ((item == `FKC_ITEM_UNIT_RES) && pend_valid) ? pend_code : rd_data;
                    end
                end
                ST_EDIT: begin
                    if (s_brief) begin
                        edit_val[15 - 4 * digit -: 4] <= next_nib;
                    end else if (p_brief) begin
                        if (digit == `FKC_DIGITS - 3'd1) begin
                            state       <= ST_BROWSE;
                            flash_digit <= 4'h0;
                            show_ok     <= 1'b1;
                            if (item == `FKC_ITEM_UNIT_RES) begin
                                pend_code  <= edit_val;
                                pend_valid <= 1'b1;
                            end else begin
                                wr_en <= 1'b1;
                            end
                        end else begin
                            digit       <= digit + 3'd1;
                            flash_digit <= flash_digit >> 1;
                        end
                    end
                end
                default: state <= ST_NORMAL;
            endcase
            // Exits: lock item hold, long primary, timeout
            if (state != ST_NORMAL) begin
                if (state == ST_BROWSE && item == `FKC_ITEM_LOCK && s_level && s_held == LOCK_CYC - 1) begin
                    access_open <= 1'b0;
                    transport   <= 1'b0;
                    to_first_reading <= 1'b1;
                    state <= ST_NORMAL;
                end else if (p_long) begin
                    to_other_menus <= 1'b1;
                    if (!transport) access_open <= 1'b0;
                    state <= ST_NORMAL;
                end else if (menu_timer >= TIMEOUT_CYC - 1) begin
                    to_first_reading <= 1'b1;
                    if (!transport) access_open <= 1'b0;
                    state <= ST_NORMAL;
                end
                if ((state == ST_BROWSE && item == `FKC_ITEM_LOCK && s_level && s_held == LOCK_CYC - 1)
                    || p_long || menu_timer >= TIMEOUT_CYC - 1) begin
                    in_menu     <= 1'b0;
                    flash_digit <= 4'h0;
                    show_ok     <= 1'b0;
                    item        <= `FKC_ITEM_FIRST;
                    if (pend_valid) begin
                        unit_res_code   <= pend_code;
                        unit_res_commit <= 1'b1;
                        pend_valid      <= 1'b0;
                    end
                end
            end
        end
    end
endmodule

//--- fkc_menu_checker.sv
// Port-level assertions for the configuration menu
`timescale 1ns/1ps
module fkc_menu_checker #(
    parameter TIMEOUT_CYC = 200
) (
    // Clock and reset
    input wire        mclk,
    input wire        rst,
    // Watched ports
    input wire        first_integration,
    input wire        in_menu,
    input wire [15:0] disp_index,
    input wire [3:0]  flash_digit,
    input wire        to_other_menus,
    input wire        to_first_reading,
    input wire        transport,
    input wire        access_open,
    input wire [4:0]  session_count
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (rst);
    wire        exit_now;
    reg  [31:0] dwell;
    // Any of the exit pulses
    assign exit_now = to_other_menus | to_first_reading;
    // Cycles spent in the menu, so the timeout has a hard bound
    always @(posedge mclk or posedge rst) begin
        if (rst)
            dwell <= 32'h0;
        else
            dwell <= in_menu ? dwell + 32'h1 : 32'h0;
    end
    a_session_cap: assert property (session_count <= 5'd25)
        else $error("session count above limit");
    a_count_step: assert property ($changed(session_count) |-> session_count == $past(session_count) + 5'd1)
        else $error("session count moved by other than one");
    a_count_at_grant: assert property ($changed(session_count) |-> ##[0:2] in_menu)
        else $error("session counted without entry");
    a_entry_gate: assert property ($rose(in_menu) |-> $past(access_open))
        else $error("menu entered while access closed");
    a_transport_sticky: assert property (!transport |=> !transport)
        else $error("transport state came back without reset");
    a_integration_leave: assert property (first_integration |-> ##[1:3] !transport)
        else $error("transport kept after integration");
    a_op_exit_locks: assert property (exit_now && !transport |-> ##[0:2] !access_open)
        else $error("operating exit left access open");
    a_tr_exit_open: assert property (exit_now && transport |-> ##[0:2] access_open)
        else $error("transport exit closed access");
    a_timeout_bound: assert property (in_menu |-> dwell <= TIMEOUT_CYC + 3)
        else $error("menu outlived its timeout");
    a_flash_onehot: assert property ($onehot0(flash_digit))
        else $error("more than one digit in focus");
    a_index_form: assert property (in_menu |-> disp_index[15:8] == 8'h30 && disp_index[7:0] inside {[8'h01:8'h22]})
        else $error("menu index out of form");
endmodule

bind fkc_menu fkc_menu_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) fkc_menu_checker_inst (
    .mclk(mclk), .rst(rst), .first_integration(first_integration), .in_menu(in_menu),
    .disp_index(disp_index), .flash_digit(flash_digit), .to_other_menus(to_other_menus),
    .to_first_reading(to_first_reading), .transport(transport), .access_open(access_open),
    .session_count(session_count));

//--- fkc_tech_model.sv
// Technician at the two front keys, plus the housing seal
`timescale 1ns/1ps
module fkc_tech_model (
    // Clock
    input  wire mclk,
    // Keys and seal, high while active
    output reg  key_primary,
    output reg  key_secondary,
    output reg  seal_break
);
    // Idle hands at power-up
    initial begin
        key_primary = 1'b0;
        key_secondary = 1'b0;
        seal_break = 1'b0;
    end
    // Steady hold of n cycles, then a rest well past the debounce time
    task press(input bit sec, input int n);
        @(posedge mclk);
        #2;
        if (sec) key_secondary = 1'b1; else key_primary = 1'b1;
        repeat (n) @(posedge mclk);
        #2;
        key_secondary = 1'b0;
        key_primary = 1'b0;
        repeat (8) @(posedge mclk);
    endtask
    // Top lifted and set back: one clean pulse on the seal line
    task break_seal();
        @(posedge mclk);
        #2;
        seal_break = 1'b1;
        repeat (4) @(posedge mclk);
        #2;
        seal_break = 1'b0;
        repeat (4) @(posedge mclk);
    endtask
endmodule

//--- fkc_menu_tb.sv
// Self-checking bench for the configuration menu
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module fkc_menu_tb;
    localparam int TO = 2000;
    reg         mclk, rst, first_integration;
    reg  [2:0]  meter_type;
    reg  [21:0] item_disabled;
    wire        key_primary, key_secondary, seal_break, in_menu, show_off, show_frames, show_ok;
    wire        to_other_menus, to_first_reading, transport, access_open, unit_res_commit;
    wire [15:0] disp_index, disp_value, unit_res_code;
    wire [3:0]  flash_digit;
    wire [4:0]  session_count;
    int         fails, n_checks, cyc, n_other, n_first, n_commit;
    bit         saw_frames;
    reg  [3:0]  v;
    reg  [15:0] code;
    fkc_tech_model fkc_tech_model_inst (.mclk(mclk), .key_primary(key_primary),
        .key_secondary(key_secondary), .seal_break(seal_break));
    // Short counts keep every timed path inside a few thousand cycles
    fkc_menu #(.DEB_CYC(2), .LONG_CYC(20), .ENTRY_CYC(40), .LOCK_CYC(30), .TIMEOUT_CYC(TO)) fkc_menu_inst (
        .mclk(mclk), .rst(rst), .key_primary(key_primary), .key_secondary(key_secondary),
        .seal_break(seal_break), .first_integration(first_integration), .access_default_on(1'b1),
        .meter_type(meter_type), .item_disabled(item_disabled), .in_menu(in_menu),
        .disp_index(disp_index), .disp_value(disp_value), .flash_digit(flash_digit),
        .show_off(show_off), .show_frames(show_frames), .show_ok(show_ok),
        .to_other_menus(to_other_menus), .to_first_reading(to_first_reading), .transport(transport),
        .access_open(access_open), .session_count(session_count), .unit_res_code(unit_res_code),
        .unit_res_commit(unit_res_commit));
    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Pulse counters and the hang limit
    always @(posedge mclk) begin
        cyc++;
        if (to_other_menus === 1'b1) n_other++;
        if (to_first_reading === 1'b1) n_first++;
        if (unit_res_commit === 1'b1) n_commit++;
        if (show_frames === 1'b1) saw_frames = 1'b1;
        if (cyc == 30000) begin
            fails++;
            tally_and_finish();
        end
    end
    task tally_and_finish();
        if (fails == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task do_reset();
        rst = 1'b1;
        repeat (8) @(posedge mclk);
        #2;
        rst = 1'b0;
        @(posedge mclk);
    endtask
    task step(input int n);
        repeat (n) fkc_tech_model_inst.press(1'b0, 6);
    endtask
    task sec();
        fkc_tech_model_inst.press(1'b1, 6);
    endtask
    // Long hold past the entry time; access is granted on release
    task enter();
        fkc_tech_model_inst.press(1'b0, 50);
    endtask
    task leave();
        fkc_tech_model_inst.press(1'b0, 30);
    endtask
    task t_reset_state();
        `CHK(transport, 1'b1)
        `CHK(access_open, 1'b1)
        `CHK(session_count, 5'd0)
        `CHK(in_menu, 1'b0)
    endtask
    // Walk the list, refuse a disabled item, edit and store the unit code
    task t_navigate_edit();
        n_other = 0;
        n_commit = 0;
        saw_frames = 1'b0;
        enter();
        `CHK(in_menu, 1'b1)
        `CHK(disp_index, 16'h3001)
        `CHK(session_count, 5'd1)
        step(1);
        `CHK(disp_index, 16'h3002)
        `CHK(show_off, 1'b1)
        sec();
        `CHK(saw_frames, 1'b1)
        `CHK(flash_digit, 4'h0)
        step(6);
        `CHK(disp_index, 16'h3008)
        sec();
        `CHK(flash_digit, 4'h8)
        v = disp_value[15:12];
        sec();
        `CHK(disp_value[15:12], (v == 4'h9) ? 4'h0 : v + 4'h1)
        step(1);
        `CHK(flash_digit, 4'h4)
        step(3);
        `CHK(show_ok, 1'b1)
        code = disp_value;
        `CHK(n_commit, 0)
        step(3);
        `CHK(disp_index, 16'h3011)
        `CHK(show_off, 1'b1)
        leave();
        `CHK(n_other, 1)
        `CHK(in_menu, 1'b0)
        `CHK(access_open, 1'b1)
        `CHK(n_commit, 1)
        `CHK(unit_res_code, code)
    endtask
    task t_timeout();
        n_first = 0;
        enter();
        repeat (TO + 20) @(posedge mclk);
        `CHK(n_first, 1)
        `CHK(in_menu, 1'b0)
        `CHK(access_open, 1'b1)
    endtask
    // Heat/cool item editable on type 6, then lock, reopen by seal, operating timeout
    task t_lock_and_seal();
        meter_type = 3'd6;
        enter();
        step(10);
        sec();
        `CHK(flash_digit, 4'h8)
        step(4);
        step(11);
        `CHK(disp_index, 16'h3022)
        fkc_tech_model_inst.press(1'b1, 40);
        `CHK(in_menu, 1'b0)
        `CHK(transport, 1'b0)
        `CHK(access_open, 1'b0)
        enter();
        `CHK(in_menu, 1'b0)
        fkc_tech_model_inst.break_seal();
        `CHK(access_open, 1'b1)
        enter();
        `CHK(in_menu, 1'b1)
        repeat (TO + 20) @(posedge mclk);
        `CHK(access_open, 1'b0)
        `CHK(transport, 1'b0)
        `CHK(session_count, 5'd4)
    endtask
    task t_integration();
        do_reset();
        @(posedge mclk);
        #2;
        first_integration = 1'b1;
        @(posedge mclk);
        #2;
        first_integration = 1'b0;
        repeat (4) @(posedge mclk);
        `CHK(transport, 1'b0)
        do_reset();
        `CHK(transport, 1'b1)
    endtask
    task t_session_limit();
        repeat (25) begin
            enter();
            leave();
        end
        `CHK(session_count, 5'd25)
        enter();
        `CHK(in_menu, 1'b0)
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        first_integration = 1'b0;
        meter_type = 3'd3;
        item_disabled = 22'h2;
        do_reset();
        t_reset_state();
        t_navigate_edit();
        t_timeout();
        t_lock_and_seal();
        t_integration();
        t_session_limit();
        tally_and_finish();
    end
endmodule
